// *** rtl/tts_pkg.sv ***
`default_nettype none
package tts_pkg;

    // ------------------------------------------------------------
    // opcode decode
    // ------------------------------------------------------------
    localparam logic [7:0] TTS_TRAP_OP_BYTE0 = 8'h08;    // first byte of trap_always_op
    localparam logic [3:0] TTS_TRAP_OP_HI_NIB = 4'h1;    // upper nibble of second byte
    localparam logic [7:0] TTS_TAS_OP_BYTE = 8'h17;      // operation byte of atomic_test_set_op

    // ------------------------------------------------------------
    // vector table layout
    // ------------------------------------------------------------
    localparam logic [15:0] TTS_VEC_BASE_MIN = 16'h0020; // two-byte entries
    localparam logic [15:0] TTS_VEC_BASE_MAX = 16'h0040; // four-byte entries
    localparam int TTS_VEC_SHIFT_MIN = 1;                // 2n
    localparam int TTS_VEC_SHIFT_MAX = 2;                // 4n
    localparam logic [23:0] TTS_WORD_STEP = 24'h000002;  // stack step per push
    localparam logic [23:0] TTS_HALF_STEP = 24'h000002;  // second word of max-mode entry

    // ------------------------------------------------------------
    // flag positions in condition_flags
    // ------------------------------------------------------------
    localparam int TTS_FLAG_N = 3;
    localparam int TTS_FLAG_Z = 2;
    localparam int TTS_FLAG_V = 1;
    localparam int TTS_FLAG_C = 0;
    localparam int TTS_BYTE_MSB = 7;

    // ------------------------------------------------------------
    // addressing-mode codes of effective_address_field
    // ------------------------------------------------------------
    typedef enum logic [3:0]
    {
        TTS_EA_REG,
        TTS_EA_IND,
        TTS_EA_D8,
        TTS_EA_D16,
        TTS_EA_PREDEC,
        TTS_EA_POSTINC,
        TTS_EA_ABS8,
        TTS_EA_ABS16,
        TTS_EA_IMM8,
        TTS_EA_IMM16
    } tts_ea_e;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [23:0] TTS_ADDR_RST = 24'h000000;
    localparam logic [15:0] TTS_DATA_RST = 16'h0000;

endpackage
`default_nettype wire

// *** rtl/tts_flag_calc.sv ***
`timescale 1ns/1ps
`default_nettype none
module tts_flag_calc
    import tts_pkg::*;
(
    input wire logic [7:0] value,
    input wire logic [3:0] flags_in,
    output logic [3:0] flags_out,
    output logic [7:0] value_set
);
    // ------------------------------------------------------------
    // flag calculation of the byte test
    // ------------------------------------------------------------
    always_comb
    begin
        flags_out = flags_in;
        flags_out[TTS_FLAG_N] = value[TTS_BYTE_MSB];
        flags_out[TTS_FLAG_Z] = (value == 8'h00);
        flags_out[TTS_FLAG_V] = 1'b0;
        flags_out[TTS_FLAG_C] = 1'b0;
        value_set = value | 8'h80;
    end
endmodule
`default_nettype wire

// *** rtl/tts_vec_addr.sv ***
`timescale 1ns/1ps
`default_nettype none
module tts_vec_addr
    import tts_pkg::*;
(
    input wire logic [3:0] vec_num,
    input wire logic max_mode,
    output logic [15:0] vec_addr
);
    // ------------------------------------------------------------
    // vector entry location
    // ------------------------------------------------------------
    logic [15:0] num_ext; // zero-extended vector number

    always_comb
    begin
        num_ext = {12'h000, vec_num};
        if (max_mode)
        begin
            vec_addr = TTS_VEC_BASE_MAX + (num_ext << TTS_VEC_SHIFT_MAX);
        end
        else
        begin
            vec_addr = TTS_VEC_BASE_MIN + (num_ext << TTS_VEC_SHIFT_MIN);
        end
    end
endmodule
`default_nettype wire

// *** rtl/tts_exec.sv ***
// Added by the designer: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module tts_exec
    import tts_pkg::*;
(
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic START,            // one-cycle pulse: begin instruction
    input wire logic [7:0] OP_BYTE0,   // first opcode byte
    input wire logic [7:0] OP_BYTE1,   // second opcode byte
    input wire logic [3:0] EA_MODE,    // effective_address_field mode code
    input wire logic [23:0] EA_ADDR,   // operand address from address unit
    input wire logic [7:0] REG_VALUE,  // register operand value
    input wire logic MAX_MODE,         // address-space mode
    input wire logic [15:0] PC_IN,     // return program counter
    input wire logic [7:0] CODE_PAGE_IN,
    input wire logic [15:0] STATUS_IN, // status_word, flags in low nibble
    input wire logic [23:0] SP_IN,     // current stack pointer
    input wire logic BUS_ACK,          // memory cycle done
    input wire logic [15:0] BUS_RDATA, // read data
    input wire logic BUS_FAULT,        // address error on current cycle
    output logic BUS_REQ,
    output logic BUS_WRITE,
    output logic BUS_BYTE,             // byte cycle, data in low byte
    output logic [23:0] BUS_ADDR,
    output logic [15:0] BUS_WDATA,
    output logic BUSY,
    output logic INT_BLOCK,            // interrupts held off
    output logic BUS_HOLD,             // bus not released
    output logic DONE,                 // one-cycle pulse
    output logic ILLEGAL,              // one-cycle pulse: refused operand
    output logic EXC_PEND,             // one-cycle pulse: deferred exception
    output logic [7:0] REG_WDATA,
    output logic REG_WE,
    output logic [3:0] FLAGS_OUT,
    output logic FLAGS_WE,
    output logic [15:0] PC_OUT,
    output logic [7:0] CODE_PAGE_OUT,
    output logic PC_WE,
    output logic CODE_PAGE_WE,
    output logic [23:0] SP_OUT,
    output logic SP_WE
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [3:0]
    {
        ST_IDLE,
        ST_TAS_RD,
        ST_TAS_WR,
        ST_PUSH_PC,
        ST_PUSH_CP,
        ST_PUSH_SR,
        ST_VEC_CP,
        ST_VEC_PC,
        ST_FINISH
    } tts_state_e;

    typedef struct packed
    {
        tts_state_e st;
        logic req;
        logic wr;
        logic byt;
        logic [23:0] addr;
        logic [15:0] wdata;
        logic [23:0] sp;      // working stack pointer
        logic [15:0] vaddr;   // vector entry address
        logic mode;           // latched address mode
        logic [15:0] pc;
        logic [7:0] cp;
        logic [15:0] sr;
        logic fault;          // deferred exception
        logic done;
        logic ill;
        logic exc;
        logic [7:0] regw;
        logic regwe;
        logic [3:0] flags;
        logic flagswe;
        logic pcwe;
        logic cpwe;
        logic spwe;
    } tts_state_s;

    tts_state_s state_r; // registered state
    tts_state_s state_nxt; // next state

    logic [7:0] tst_val; // byte under test
    logic [3:0] tst_flags; // flags from the test
    logic [7:0] tst_set; // value with bit 7 forced
    logic [15:0] vec_addr; // vector entry from decoded number
    logic is_trap; // decoded trap_always_op
    logic is_tas; // decoded atomic_test_set_op
    logic ea_imm; // immediate mode requested

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    tts_flag_calc u_flag
    (
        .value(tst_val),
        .flags_in(STATUS_IN[3:0]),
        .flags_out(tst_flags),
        .value_set(tst_set)
    );

    tts_vec_addr u_vec
    (
        .vec_num(OP_BYTE1[3:0]),
        .max_mode(MAX_MODE),
        .vec_addr(vec_addr)
    );

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    always_comb
    begin
        is_trap = (OP_BYTE0 == TTS_TRAP_OP_BYTE0) && (OP_BYTE1[7:4] == TTS_TRAP_OP_HI_NIB);
        is_tas = (OP_BYTE1 == TTS_TAS_OP_BYTE);
        ea_imm = (EA_MODE == TTS_EA_IMM8) || (EA_MODE == TTS_EA_IMM16);
        // register operand taken straight, memory operand from the bus
        if (state_r.st == ST_TAS_RD)
        begin
            tst_val = BUS_RDATA[7:0];
        end
        else
        begin
            tst_val = REG_VALUE;
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb
    begin
        state_nxt = state_r;
        // strobes last a single cycle
        state_nxt.done = 1'b0;
        state_nxt.ill = 1'b0;
        state_nxt.exc = 1'b0;
        state_nxt.regwe = 1'b0;
        state_nxt.flagswe = 1'b0;
        state_nxt.pcwe = 1'b0;
        state_nxt.cpwe = 1'b0;
        state_nxt.spwe = 1'b0;
        case (state_r.st)
            ST_IDLE:
            begin
                if (START && is_trap)
                begin
                    // mode, context taken at execution time
                    state_nxt.mode = MAX_MODE;
                    state_nxt.pc = PC_IN;
                    state_nxt.cp = CODE_PAGE_IN;
                    state_nxt.sr = STATUS_IN;
                    state_nxt.vaddr = vec_addr;
                    state_nxt.sp = SP_IN - TTS_WORD_STEP;
                    state_nxt.addr = SP_IN - TTS_WORD_STEP;
                    state_nxt.wdata = PC_IN;
                    state_nxt.req = 1'b1;
                    state_nxt.wr = 1'b1;
                    state_nxt.byt = 1'b0;
                    state_nxt.st = ST_PUSH_PC;
                end
                else if (START && is_tas && ea_imm)
                begin
                    state_nxt.ill = 1'b1;
                    state_nxt.done = 1'b1;
                end
                else if (START && is_tas && EA_MODE == TTS_EA_REG)
                begin
                    state_nxt.regw = tst_set;
                    state_nxt.regwe = 1'b1;
                    state_nxt.flags = tst_flags;
                    state_nxt.flagswe = 1'b1;
                    state_nxt.done = 1'b1;
                end
                else if (START && is_tas)
                begin
                    // byte read opens the locked pair
                    state_nxt.addr = EA_ADDR;
                    state_nxt.req = 1'b1;
                    state_nxt.wr = 1'b0;
                    state_nxt.byt = 1'b1;
                    state_nxt.fault = 1'b0;
                    state_nxt.st = ST_TAS_RD;
                end
            end
            ST_TAS_RD:
            begin
                if (BUS_ACK)
                begin
                    // fault is held, not taken, until the write ends
                    state_nxt.fault = BUS_FAULT;
                    state_nxt.flags = tst_flags;
                    state_nxt.flagswe = 1'b1;
                    state_nxt.wdata = {8'h00, tst_set};
                    state_nxt.wr = 1'b1;
                    state_nxt.st = ST_TAS_WR;
                end
            end
            ST_TAS_WR:
            begin
                if (BUS_ACK)
                begin
                    state_nxt.req = 1'b0;
                    state_nxt.wr = 1'b0;
                    state_nxt.exc = state_r.fault | BUS_FAULT;
                    state_nxt.done = 1'b1;
                    state_nxt.st = ST_IDLE;
                end
            end
            ST_PUSH_PC:
            begin
                if (BUS_ACK)
                begin
                    state_nxt.sp = state_r.sp - TTS_WORD_STEP;
                    state_nxt.addr = state_r.sp - TTS_WORD_STEP;
                    if (state_r.mode)
                    begin
                        state_nxt.wdata = {8'h00, state_r.cp};
                        state_nxt.st = ST_PUSH_CP;
                    end
                    else
                    begin
                        state_nxt.wdata = state_r.sr;
                        state_nxt.st = ST_PUSH_SR;
                    end
                end
            end
            ST_PUSH_CP:
            begin
                if (BUS_ACK)
                begin
                    state_nxt.sp = state_r.sp - TTS_WORD_STEP;
                    state_nxt.addr = state_r.sp - TTS_WORD_STEP;
                    state_nxt.wdata = state_r.sr;
                    state_nxt.st = ST_PUSH_SR;
                end
            end
            ST_PUSH_SR:
            begin
                if (BUS_ACK)
                begin
                    state_nxt.wr = 1'b0;
                    state_nxt.addr = {8'h00, state_r.vaddr};
                    // max-mode entry holds page word first, then PC
                    state_nxt.st = state_r.mode ? ST_VEC_CP : ST_VEC_PC;
                end
            end
            ST_VEC_CP:
            begin
                if (BUS_ACK)
                begin
                    state_nxt.cp = BUS_RDATA[7:0];
                    state_nxt.addr = {8'h00, state_r.vaddr} + TTS_HALF_STEP;
                    state_nxt.st = ST_VEC_PC;
                end
            end
            ST_VEC_PC:
            begin
                if (BUS_ACK)
                begin
                    state_nxt.req = 1'b0;
                    state_nxt.pc = BUS_RDATA;
                    state_nxt.st = ST_FINISH;
                end
            end
            ST_FINISH:
            begin
                // flags are never written on this path
                state_nxt.pcwe = 1'b1;
                state_nxt.cpwe = state_r.mode;
                state_nxt.spwe = 1'b1;
                state_nxt.done = 1'b1;
                state_nxt.st = ST_IDLE;
            end
            default:
            begin
                state_nxt.st = ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            state_r <= '0;
            state_r.st <= ST_IDLE;
            state_r.addr <= TTS_ADDR_RST;
            state_r.wdata <= TTS_DATA_RST;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs; BUS_HOLD and INT_BLOCK mark the locked pair
    // ------------------------------------------------------------
    always_comb
    begin
        BUS_REQ = state_r.req;
        BUS_WRITE = state_r.wr;
        BUS_BYTE = state_r.byt && (state_r.st == ST_TAS_RD || state_r.st == ST_TAS_WR);
        BUS_ADDR = state_r.addr;
        BUS_WDATA = state_r.wdata;
        BUSY = (state_r.st != ST_IDLE);
        INT_BLOCK = (state_r.st == ST_TAS_RD) || (state_r.st == ST_TAS_WR);
        BUS_HOLD = INT_BLOCK;
        DONE = state_r.done;
        ILLEGAL = state_r.ill;
        EXC_PEND = state_r.exc;
        REG_WDATA = state_r.regw;
        REG_WE = state_r.regwe;
        FLAGS_OUT = state_r.flags;
        FLAGS_WE = state_r.flagswe;
        PC_OUT = state_r.pc;
        CODE_PAGE_OUT = state_r.cp;
        PC_WE = state_r.pcwe;
        CODE_PAGE_WE = state_r.cpwe;
        SP_OUT = state_r.sp;
        SP_WE = state_r.spwe;
    end
endmodule
`default_nettype wire

// *** tb/tts_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// byte array behind the core's bus, big-endian words
module tts_mem_model
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic req,
    input wire logic wr,
    input wire logic byte_op,
    input wire logic [23:0] addr,
    input wire logic [15:0] wdata,
    input wire logic [1:0] wait_n,
    input wire logic fault_en,
    input wire logic [23:0] fault_addr,
    output logic ack,
    output logic [15:0] rdata,
    output logic fault
);
    logic [7:0] mem [0:255]; // low address byte only, upper bits alias
    logic [1:0] cnt_r; // wait states spent on this cycle
    logic go; // cycle completes at this edge
    logic [7:0] a; // array index
    assign a = addr[7:0];
    assign go = req && !ack && cnt_r == wait_n;
    // ack lasts one cycle; rdata toggles when it carries nothing,
    // so a late sample of the bus never sees a stale match
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ack <= 1'b0;
            fault <= 1'b0;
            rdata <= 16'hA5A5;
            cnt_r <= 2'h0;
        end
        else
        begin
            ack <= go;
            fault <= go && fault_en && addr == fault_addr;
            cnt_r <= (req && !ack && !go) ? cnt_r + 2'h1 : 2'h0;
            rdata <= ~rdata;
            if (go && !wr)
                rdata <= byte_op ? {~mem[a], mem[a]} : {mem[a], mem[a + 8'h01]};
            if (go && wr && byte_op)
                mem[a] <= wdata[7:0];
            else if (go && wr)
            begin
                mem[a] <= wdata[15:8];
                mem[a + 8'h01] <= wdata[7:0];
            end
        end
    end
endmodule
`default_nettype wire

// *** tb/tts_exec_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module tts_exec_sva
    import tts_pkg::*;
(
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic START,
    input wire logic [7:0] OP_BYTE0,
    input wire logic [7:0] OP_BYTE1,
    input wire logic [3:0] EA_MODE,
    input wire logic [7:0] REG_VALUE,
    input wire logic [15:0] PC_IN,
    input wire logic [23:0] SP_IN,
    input wire logic BUS_ACK,
    input wire logic [15:0] BUS_RDATA,
    input wire logic BUS_FAULT,
    input wire logic BUS_REQ,
    input wire logic BUS_WRITE,
    input wire logic BUS_BYTE,
    input wire logic [23:0] BUS_ADDR,
    input wire logic [15:0] BUS_WDATA,
    input wire logic BUSY,
    input wire logic INT_BLOCK,
    input wire logic BUS_HOLD,
    input wire logic DONE,
    input wire logic ILLEGAL,
    input wire logic EXC_PEND,
    input wire logic [7:0] REG_WDATA,
    input wire logic [3:0] FLAGS_OUT,
    input wire logic FLAGS_WE
);
    // ----------------
    // request decode
    // ----------------
    logic tas_go; // accepted test-and-set
    logic trap_go; // accepted trap
    logic rd_ack; // locked byte read ends
    logic wr_ack; // locked byte write ends
    logic in_trap_r; // trap in flight, up to its done pulse
    assign tas_go = START && !BUSY && OP_BYTE1 == TTS_TAS_OP_BYTE && OP_BYTE0 != TTS_TRAP_OP_BYTE0;
    assign trap_go = START && !BUSY && OP_BYTE0 == TTS_TRAP_OP_BYTE0 && OP_BYTE1[7:4] == TTS_TRAP_OP_HI_NIB;
    assign rd_ack = BUS_REQ && BUS_ACK && BUS_BYTE && !BUS_WRITE;
    assign wr_ack = BUS_REQ && BUS_ACK && BUS_BYTE && BUS_WRITE;
    // trap window for the flag hold check
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            in_trap_r <= 1'b0;
        else if (trap_go || DONE)
            in_trap_r <= trap_go;
    end
    default clocking dcb @(posedge CLK);
    endclocking
    default disable iff (!RESET_N);
    // ----------------
    // assertions
    // ----------------
    a_reg_tas_data: assert property (tas_go && EA_MODE == 4'h0 |=> DONE && REG_WDATA == ($past(REG_VALUE) | 8'h80))
        else $error("register operand result wrong");
    a_reg_tas_flags: assert property (tas_go && EA_MODE == 4'h0 |=> FLAGS_WE && FLAGS_OUT == {$past(REG_VALUE[7]), $past(REG_VALUE) == 8'h00, 2'b00})
        else $error("register operand flags wrong");
    a_imm_refused: assert property (tas_go && (EA_MODE == 4'h8 || EA_MODE == 4'h9) |=> ILLEGAL && DONE && !BUS_REQ)
        else $error("immediate operand not refused");
    a_rmw_write: assert property (rd_ack |=> BUS_REQ && BUS_WRITE && BUS_ADDR == $past(BUS_ADDR) && BUS_WDATA[7:0] == ($past(BUS_RDATA[7:0]) | 8'h80))
        else $error("locked write does not follow read");
    a_lock_held: assert property (BUS_REQ && BUS_BYTE |-> INT_BLOCK && BUS_HOLD)
        else $error("lock dropped inside locked sequence");
    a_rmw_done: assert property (wr_ack |=> DONE && !BUS_REQ && !INT_BLOCK && !BUS_HOLD)
        else $error("locked sequence not closed");
    a_exc_defer: assert property (rd_ack && BUS_FAULT |=> !EXC_PEND ##[1:60] (DONE && EXC_PEND))
        else $error("read fault not deferred to the end");
    a_trap_first: assert property (trap_go |=> BUS_REQ && BUS_WRITE && BUS_ADDR == $past(SP_IN) - 24'h000002 && BUS_WDATA == $past(PC_IN))
        else $error("first trap push wrong");
    a_push_step: assert property (BUS_ACK && BUS_REQ && BUS_WRITE && !BUS_BYTE |=> !(BUS_REQ && BUS_WRITE) || BUS_ADDR == $past(BUS_ADDR) - 24'h000002)
        else $error("trap push not two below the last");
    a_trap_flags: assert property (in_trap_r |-> !FLAGS_WE)
        else $error("trap wrote the flags");
    c_fault_read: cover property (rd_ack && BUS_FAULT);
    c_refused: cover property (ILLEGAL);
    c_trap_done: cover property (in_trap_r && DONE);
endmodule
bind tts_exec tts_exec_sva u_sva (.*);
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin n_fail++; $display("BAD %s exp %h seen %h", nm, ex, gt); end end
module tb_top
    import tts_pkg::*;
;
    // ----------------
    // design hook-up, named as the design's ports
    // ----------------
    logic CLK, RESET_N, START, MAX_MODE, BUS_ACK, BUS_FAULT, fen;
    logic [7:0] OP_BYTE0, OP_BYTE1, REG_VALUE, CODE_PAGE_IN, REG_WDATA, CODE_PAGE_OUT, reg_seen, cp_seen;
    logic [3:0] EA_MODE, FLAGS_OUT, fl_seen;
    logic [23:0] EA_ADDR, SP_IN, BUS_ADDR, SP_OUT, faddr, sp_seen;
    logic [15:0] PC_IN, STATUS_IN, BUS_RDATA, BUS_WDATA, PC_OUT, pc_seen;
    logic BUS_REQ, BUS_WRITE, BUS_BYTE, BUSY, INT_BLOCK, BUS_HOLD, DONE, ILLEGAL, EXC_PEND;
    logic REG_WE, FLAGS_WE, PC_WE, CODE_PAGE_WE, SP_WE;
    logic [1:0] dly; // memory wait states, random per operation
    logic [31:0] seed, r;
    logic [41:0] log_q[$], exp_q[$]; // {write, byte, addr, data}
    int compares, n_fail, n_done, n_flag, n_ill, n_exc;
    logic [15:0] pc_v, st_v, va, w0, w1;
    logic [7:0] cp_v, v;
    logic [23:0] sp_v, ad;
    logic [3:0] n;
    tts_exec DUT (.*);
    tts_mem_model mem (.clk(CLK), .rst_n(RESET_N), .req(BUS_REQ), .wr(BUS_WRITE), .byte_op(BUS_BYTE),
        .addr(BUS_ADDR), .wdata(BUS_WDATA), .wait_n(dly), .fault_en(fen), .fault_addr(faddr),
        .ack(BUS_ACK), .rdata(BUS_RDATA), .fault(BUS_FAULT));
    initial
    begin
        CLK = 1'b0;
        forever #25 CLK = ~CLK;
    end
    // watchdog, far beyond the thousand or so cycles expected
    initial
    begin
        #1000000;
        n_fail++;
        end_of_test();
    end
    // ----------------
    // monitor: sampled mid-cycle, when all outputs have settled
    // ----------------
    always @(negedge CLK)
    begin
        if (BUS_REQ && BUS_ACK)
            log_q.push_back({BUS_WRITE, BUS_BYTE, BUS_ADDR, BUS_BYTE ?
                {8'h00, BUS_WRITE ? BUS_WDATA[7:0] : BUS_RDATA[7:0]} : BUS_WRITE ? BUS_WDATA : BUS_RDATA});
        n_done += DONE;
        n_ill += ILLEGAL;
        n_exc += EXC_PEND;
        n_flag += FLAGS_WE;
        if (FLAGS_WE)
            fl_seen = FLAGS_OUT;
        if (REG_WE)
            reg_seen = REG_WDATA;
        if (PC_WE)
            pc_seen = PC_OUT;
        if (CODE_PAGE_WE)
            cp_seen = CODE_PAGE_OUT;
        if (SP_WE)
            sp_seen = SP_OUT;
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // one instruction: fresh context values, a start pulse, bounded wait for done
    task automatic issue(input logic [7:0] b0, input logic [7:0] b1, input logic [3:0] m,
                         input logic [23:0] a, input logic [7:0] rv, input logic mx);
        int k;
        log_q.delete();
        n_done = 0;
        n_ill = 0;
        n_exc = 0;
        n_flag = 0;
        {fl_seen, reg_seen, pc_seen, cp_seen, sp_seen} = 'x;
        r = rnd();
        pc_v = r[15:0];
        st_v = r[31:16];
        r = rnd();
        cp_v = r[7:0];
        sp_v = {r[23:8], 8'hF0};
        @(posedge CLK);
        {OP_BYTE0, OP_BYTE1, EA_MODE, EA_ADDR, REG_VALUE, MAX_MODE} <= {b0, b1, m, a, rv, mx};
        {PC_IN, STATUS_IN, CODE_PAGE_IN, SP_IN, dly} <= {pc_v, st_v, cp_v, sp_v, r[31:30]};
        START <= 1'b1;
        @(posedge CLK);
        // mode flips once taken; only the latched mode may steer the trap
        {START, MAX_MODE} <= {1'b0, ~mx};
        for (k = 0; k < 60 && n_done == 0; k++)
            @(negedge CLK);
        repeat (3) @(negedge CLK);
    endtask
    task automatic cmp_log();
        int i;
        `CHK("bus cycle count", exp_q.size(), log_q.size())
        for (i = 0; i < exp_q.size() && i < log_q.size(); i++)
            `CHK("bus cycle", exp_q[i], log_q[i])
    endtask
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // ----------------
    // tests
    // ----------------
    initial
    begin
        int i, j;
        seed = 32'h00005208;
        {compares, n_fail} = 0;
        {RESET_N, START, MAX_MODE, fen, dly, faddr} = '0;
        {OP_BYTE0, OP_BYTE1, EA_MODE, EA_ADDR, REG_VALUE} = '0;
        {PC_IN, STATUS_IN, CODE_PAGE_IN, SP_IN} = '0;
        for (i = 32; i < 128; i++)
            mem.mem[i] = 8'(rnd());
        repeat (16) @(posedge CLK);
        RESET_N <= 1'b1;
        // register operand: zero, sign-only, all-but-sign, random
        for (i = 0; i < 4; i++)
        begin
            r = rnd();
            v = (i == 0) ? 8'h00 : (i == 1) ? 8'h80 : (i == 2) ? 8'h7F : r[7:0];
            issue({1'b1, r[14:8]}, TTS_TAS_OP_BYTE, 4'h0, 24'h0, v, r[15]);
            `CHK("reg result", v | 8'h80, reg_seen)
            `CHK("reg flags", {v[7], v == 8'h00, 2'b00}, fl_seen)
        end
        $display("test register operand done");
        // memory operand, every memory mode, then again with a read fault
        for (j = 0; j < 14; j++)
        begin
            r = rnd();
            n = 4'(1 + j % 7);
            ad = {r[31:16], 8'hA0 + {4'h0, n}};
            v = r[7:0];
            mem.mem[ad[7:0]] = v;
            fen = (j >= 7);
            faddr = ad;
            issue(8'h80, TTS_TAS_OP_BYTE, n, ad, 8'h00, r[8]);
            exp_q = '{{2'b01, ad, 8'h00, v}, {2'b11, ad, 8'h00, v | 8'h80}};
            cmp_log();
            `CHK("mem flags", {v[7], v == 8'h00, 2'b00}, fl_seen)
            `CHK("deferred exception", (j >= 7) ? 1 : 0, n_exc)
            `CHK("mem result", v | 8'h80, mem.mem[ad[7:0]])
        end
        fen = 1'b0;
        $display("test memory operand done");
        for (i = 8; i < 10; i++)
        begin
            issue(8'h80, TTS_TAS_OP_BYTE, 4'(i), 24'h0000A0, 8'h00, 1'b0);
            `CHK("refused", 1, n_ill)
            `CHK("refused bus", 0, log_q.size())
        end
        // second byte with the wrong upper nibble is no trap
        issue(TTS_TRAP_OP_BYTE0, 8'h25, 4'h0, 24'h0, 8'h00, 1'b0);
        `CHK("ignored opcode", 0, n_done + log_q.size())
        $display("test refusals done");
        // every vector, mode flipping from one trap to the next
        for (j = 0; j < 32; j++)
        begin
            n = j[4:1];
            issue(TTS_TRAP_OP_BYTE0, {TTS_TRAP_OP_HI_NIB, n}, 4'h0, 24'h0, 8'h00, j[0]);
            va = j[0] ? 16'h0040 + {10'h000, n, 2'b00} : 16'h0020 + {11'h000, n, 1'b0};
            w0 = {mem.mem[va[7:0]], mem.mem[va[7:0] + 8'h01]};
            w1 = {mem.mem[va[7:0] + 8'h02], mem.mem[va[7:0] + 8'h03]};
            exp_q = '{{2'b10, sp_v - 24'h000002, pc_v}};
            if (j[0])
                exp_q.push_back({2'b10, sp_v - 24'h000004, 8'h00, cp_v});
            exp_q.push_back({2'b10, sp_v - (j[0] ? 24'h000006 : 24'h000004), st_v});
            exp_q.push_back({2'b00, 8'h00, va, w0});
            if (j[0])
                exp_q.push_back({2'b00, 8'h00, va + 16'h0002, w1});
            cmp_log();
            `CHK("trap pc", j[0] ? w1 : w0, pc_seen)
            `CHK("trap sp", sp_v - (j[0] ? 24'h000006 : 24'h000004), sp_seen)
            `CHK("trap page", j[0] ? w0[7:0] : 8'hXX, cp_seen)
            `CHK("trap idle", 1'b0, BUSY)
            `CHK("trap flags", 0, n_flag)
        end
        $display("test trap done");
        end_of_test();
    end
endmodule
`default_nettype wire
